// file: rtl/dsr_pkg.sv
// dsr_pkg: constants, register indices and carrier types for the
// synchroniser status register bank.
// assumes: an ahb-lite master with 32-bit data, one word per register.
package dsr_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_LOOP_FREQUENCY_READOUT_LOW = 8'h0c;
    localparam logic [7:0] IDX_LOOP_FREQUENCY_READOUT_MID = 8'h0d;
    localparam logic [7:0] IDX_LOOP_FREQUENCY_READOUT_HIGH = 8'h07;
    localparam logic [7:0] IDX_EVENT_STATUS_THREE = 8'h08;
    localparam logic [7:0] IDX_OPERATING_STATE = 8'h09;
    localparam logic [7:0] IDX_PRIORITY_TABLE_ONE = 8'h0a;
    localparam logic [7:0] IDX_PRIORITY_TABLE_TWO = 8'h0b;
    localparam logic [7:0] IDX_EVENT_ENABLE_THREE = 8'h30;
    localparam logic [7:0] IDX_MODE_CONTROL_ELEVEN = 8'h31;
    localparam logic [7:0] IDX_MODE_CONTROL_THREE = 8'h32;
    localparam logic [7:0] IDX_VALIDATION_CONTROL_ONE = 8'h33;
    localparam logic [7:0] IDX_VALIDATION_CONTROL_TWO = 8'h34;

    // latched event bit positions
    localparam int EVT_FRAME_SYNC = 7;
    localparam int EVT_AUX_LOCK = 6;
    localparam int EVT_PHASE_MON = 5;
    localparam int EVT_AUX_NO_INPUT = 4;
    localparam logic [7:0] EVT_MASK = 8'hf0;

    // control bit positions
    localparam int PATH_VIEW_BIT = 0;
    localparam int REVERTIVE_ENABLE_BIT = 0;
    localparam int VAL2_IC9_BIT = 0;
    localparam int VAL1_IC8_BIT = 7;

    // reset values
    localparam logic [7:0] RST_EVENT_STATUS = 8'h50;
    localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
    localparam logic [7:0] RST_VALIDATION_ONE = 8'hbf;
    localparam logic [7:0] RST_VALIDATION_TWO = 8'h01;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // reference codes
    localparam logic [3:0] REF_NONE = 4'h0;
    localparam logic [3:0] REF_IC6 = 4'h6;
    localparam logic [3:0] REF_IC8 = 4'h8;
    localparam logic [3:0] REF_IC9 = 4'h9;

    // main loop state codes
    localparam logic [2:0] MAIN_FREE_RUN = 3'h1;
    localparam logic [2:0] MAIN_HOLDOVER = 3'h2;
    localparam logic [2:0] MAIN_LOCKED = 3'h4;
    localparam logic [2:0] MAIN_PRELOCKED_2 = 3'h5;
    localparam logic [2:0] MAIN_PRELOCKED = 3'h6;
    localparam logic [2:0] MAIN_LOSS_OF_LOCK = 3'h7;

    // frequency readout: two's complement, one count = this many ppm
    localparam real LOOP_FREQUENCY_READOUT_PPM_PER_COUNT = 0.0003068;
    localparam int LOOP_FREQUENCY_READOUT_WIDTH = 19;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    // ranking and selection from the priority logic of one loop
    typedef struct packed {
        logic [3:0] top;
        logic [3:0] second;
        logic [3:0] third;
        logic [3:0] selected;
    } dsr_refs_t;

    // whole state of the bank
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] enable;
        logic path_view;
        logic revertive_enable;
        logic [7:0] val1;
        logic [7:0] val2;
        logic prev_frame_sync_monitor_alarm;
        logic prev_lock;
        logic prev_phase_monitor_alarm;
        logic [LOOP_FREQUENCY_READOUT_WIDTH-1:0] loop_frequency_readout_snap;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_idx;
        logic [31:0] rdata;
        logic ready;
        logic irq;
    } dsr_state_t;

endpackage : dsr_pkg

// file: rtl/dsr_status_regs.sv
// dsr_status_regs: latched events, live operating state, reference
// priority readout and loop frequency readout behind an ahb-lite slave.
// assumes: all status inputs synchronous to hclk; single word transfers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [R01] frequency bits 18:16 in third register low bits
// [R02] frame-sync alarm rising edge latches event bit
// [R03] aux lock change either way latches bit
// [R04] phase monitor limit exceeded latches alarm bit
// [R05] aux no-input bit not clearable while present
// [R06] interrupt while enabled latched event set
// [R07] live frame-sync alarm in state bit 7
// [R08] live aux lock status in state bit 6
// [R09] main loop soft alarm in bit 5
// [R10] aux loop soft alarm in bit 4
// [R11] main loop state three-bit code field
// [R12] top valid reference in table one upper
// [R13] reference codes one-six, eight, nine only
// [R14] never report software-invalidated references
// [R15] selected reference in table one low nibble
// [R16] path view select picks main or aux
// [R17] selected and top may differ nonrevertive
// [R18] second valid reference in table two low
// [R19] third valid reference in table two upper
// [R20] frequency two's complement offset from master clock
// [R21] software reads frequency registers consecutively
// [R22] zero writes and read-only writes ignored
module dsr_status_regs
    import dsr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // live status from the loops and monitors
    input wire logic frame_sync_monitor_alarm,
    input wire logic aux_loop_lock,
    input wire logic phase_monitor_alarm,
    input wire logic aux_no_valid_input,
    input wire logic main_loop_soft_alarm,
    input wire logic aux_loop_soft_alarm,
    input wire logic [2:0] main_loop_state,
    input wire logic [LOOP_FREQUENCY_READOUT_WIDTH-1:0] main_loop_frequency,
    input wire logic [LOOP_FREQUENCY_READOUT_WIDTH-1:0] aux_loop_frequency,
    // ranking from the priority logic
    input wire dsr_refs_t main_refs,
    input wire dsr_refs_t aux_refs,
    // interrupt
    output logic interrupt_request_out
);

    dsr_state_t s_r;
    dsr_state_t s_nxt;

    // reference passes only if a known input and validated by software
    function automatic logic [3:0] ref_filter(input logic [3:0] code,
                                              input logic [7:0] v1,
                                              input logic [7:0] v2);
        logic ok;
        ok = 1'b0;
        if (code != REF_NONE && code <= REF_IC6) begin
            ok = v1[code[2:0] - 3'd1]; // [R13] [R14]
        end else if (code == REF_IC8) begin
            ok = v1[VAL1_IC8_BIT]; // [R13] [R14]
        end else if (code == REF_IC9) begin
            ok = v2[VAL2_IC9_BIT]; // [R13] [R14]
        end
        return ok ? code : REF_NONE;
    endfunction : ref_filter

    // ranks close up so a dropped entry never leaves a hole
    function automatic logic [11:0] rank_pack(input logic [3:0] a,
                                              input logic [3:0] b,
                                              input logic [3:0] c);
        logic [11:0] list;
        list = {3{REF_NONE}};
        if (a != REF_NONE) begin
            list = {list[7:0], a};
        end
        if (b != REF_NONE) begin
            list = {list[7:0], b};
        end
        if (c != REF_NONE) begin
            list = {list[7:0], c};
        end
        // oldest pushed entry sits highest; realign to first-in-low
        if (list[11:8] == REF_NONE && list[7:4] == REF_NONE) begin
            list = {8'h00, list[3:0]};
        end else if (list[11:8] == REF_NONE) begin
            list = {4'h0, list[3:0], list[7:4]};
        end else begin
            list = {list[3:0], list[7:4], list[11:8]};
        end
        return list;
    endfunction : rank_pack

    dsr_refs_t view_refs;
    logic [3:0] ref_top;
    logic [3:0] ref_second;
    logic [3:0] ref_third;
    logic [3:0] ref_sel;
    logic [11:0] ranked;
    logic [LOOP_FREQUENCY_READOUT_WIDTH-1:0] live_loop_frequency_readout;
    logic [7:0] op_state;
    logic addr_ok;
    logic take;
    logic [7:0] a_idx;
    logic [7:0] events;
    logic [7:0] w1c;

    always_comb begin
        // view choice: 0 main loop, 1 aux loop
        view_refs = s_r.path_view ? aux_refs : main_refs; // [R16]
        live_loop_frequency_readout = s_r.path_view ? aux_loop_frequency
                                  : main_loop_frequency; // [R16] [R20]
        ranked = rank_pack(
            ref_filter(view_refs.top, s_r.val1, s_r.val2),
            ref_filter(view_refs.second, s_r.val1, s_r.val2),
            ref_filter(view_refs.third, s_r.val1, s_r.val2));
        ref_top = ranked[3:0]; // [R12]
        ref_second = ranked[7:4]; // [R18]
        ref_third = ranked[11:8]; // [R19]
        // selection kept apart from ranking; they may differ [R17]
        ref_sel = ref_filter(view_refs.selected, s_r.val1,
                             s_r.val2); // [R15] [R14]
        op_state = {frame_sync_monitor_alarm, // [R07]
                    aux_loop_lock, // [R08]
                    main_loop_soft_alarm, // [R09]
                    aux_loop_soft_alarm, // [R10]
                    1'b0,
                    main_loop_state}; // [R11]
    end

    always_comb begin
        s_nxt = s_r;
        addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
        a_idx = haddr[9:2];
        take = hsel && hready && (htrans == HTRANS_NONSEQ);
        w1c = 8'h00;

        // event detection, then software clear, set wins
        events = 8'h00;
        events[EVT_FRAME_SYNC] = frame_sync_monitor_alarm
                                 && !s_r.prev_frame_sync_monitor_alarm; // [R02]
        events[EVT_AUX_LOCK] = aux_loop_lock
                               != s_r.prev_lock; // [R03]
        events[EVT_PHASE_MON] = phase_monitor_alarm
                                && !s_r.prev_phase_monitor_alarm; // [R04]
        // level, so a clear while the condition holds is undone
        events[EVT_AUX_NO_INPUT] = aux_no_valid_input; // [R05]
        s_nxt.prev_frame_sync_monitor_alarm = frame_sync_monitor_alarm;
        s_nxt.prev_lock = aux_loop_lock;
        s_nxt.prev_phase_monitor_alarm = phase_monitor_alarm;

        // data phase of a write
        if (s_r.dp_valid && s_r.dp_write) begin
            unique case (s_r.dp_idx)
                IDX_EVENT_STATUS_THREE: begin
                    // zero bits leave the flag alone [R22]
                    w1c = hwdata[7:0] & EVT_MASK; // [R02] [R03]
                end
                IDX_EVENT_ENABLE_THREE: begin
                    s_nxt.enable = hwdata[7:0] & EVT_MASK;
                end
                IDX_MODE_CONTROL_ELEVEN: begin
                    s_nxt.path_view = hwdata[PATH_VIEW_BIT]; // [R16]
                end
                IDX_MODE_CONTROL_THREE: begin
                    s_nxt.revertive_enable = hwdata[REVERTIVE_ENABLE_BIT]; // [R17]
                end
                IDX_VALIDATION_CONTROL_ONE: begin
                    s_nxt.val1 = hwdata[7:0] & RST_VALIDATION_ONE;
                end
                IDX_VALIDATION_CONTROL_TWO: begin
                    s_nxt.val2 = hwdata[7:0] & RST_VALIDATION_TWO;
                end
                // operating state, tables and frequency are read-only
                default: begin
                    w1c = 8'h00; // [R22]
                end
            endcase
        end
        s_nxt.status = ((s_r.status & ~w1c) | events)
                       & EVT_MASK; // [R04] [R05]

        // address phase: capture, and prepare read data now so
        // hrdata comes from a flop with no wait state
        s_nxt.dp_valid = take;
        s_nxt.dp_write = hwrite;
        s_nxt.dp_idx = addr_ok ? a_idx : 8'hff;
        s_nxt.ready = 1'b1;
        if (take && !hwrite) begin
            s_nxt.rdata = RDATA_ZERO;
            if (addr_ok) begin
                unique case (a_idx)
                    IDX_LOOP_FREQUENCY_READOUT_LOW: begin
                        // low byte read freezes the word [R21]
                        s_nxt.loop_frequency_readout_snap = live_loop_frequency_readout;
                        s_nxt.rdata[7:0] = live_loop_frequency_readout[7:0]; // [R20]
                    end
                    IDX_LOOP_FREQUENCY_READOUT_MID: begin
                        s_nxt.rdata[7:0] = s_r.loop_frequency_readout_snap[15:8]; // [R21]
                    end
                    IDX_LOOP_FREQUENCY_READOUT_HIGH: begin
                        s_nxt.rdata[2:0] = s_r.loop_frequency_readout_snap[18:16]; // [R01]
                    end
                    IDX_EVENT_STATUS_THREE: begin
                        s_nxt.rdata[7:0] = s_r.status;
                    end
                    IDX_OPERATING_STATE: begin
                        s_nxt.rdata[7:0] = op_state;
                    end
                    IDX_PRIORITY_TABLE_ONE: begin
                        s_nxt.rdata[7:0] = {ref_top, ref_sel}; // [R12]
                    end
                    IDX_PRIORITY_TABLE_TWO: begin
                        s_nxt.rdata[7:0] = {ref_third,
                                            ref_second}; // [R18] [R19]
                    end
                    IDX_EVENT_ENABLE_THREE: begin
                        s_nxt.rdata[7:0] = s_r.enable;
                    end
                    IDX_MODE_CONTROL_ELEVEN: begin
                        s_nxt.rdata[PATH_VIEW_BIT] = s_r.path_view;
                    end
                    IDX_MODE_CONTROL_THREE: begin
                        s_nxt.rdata[REVERTIVE_ENABLE_BIT] = s_r.revertive_enable;
                    end
                    IDX_VALIDATION_CONTROL_ONE: begin
                        s_nxt.rdata[7:0] = s_r.val1;
                    end
                    IDX_VALIDATION_CONTROL_TWO: begin
                        s_nxt.rdata[7:0] = s_r.val2;
                    end
                    // unmapped words read as zero, still okay
                    default: begin
                        s_nxt.rdata = RDATA_ZERO;
                    end
                endcase
            end
        end

        s_nxt.irq = |(s_nxt.status & s_nxt.enable); // [R06]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.status <= RST_EVENT_STATUS;
            s_r.enable <= RST_EVENT_ENABLE;
            s_r.path_view <= 1'b0;
            s_r.revertive_enable <= 1'b0;
            s_r.val1 <= RST_VALIDATION_ONE;
            s_r.val2 <= RST_VALIDATION_TWO;
            s_r.prev_frame_sync_monitor_alarm <= 1'b0;
            s_r.prev_lock <= 1'b0;
            s_r.prev_phase_monitor_alarm <= 1'b0;
            s_r.loop_frequency_readout_snap <= '0;
            s_r.dp_valid <= 1'b0;
            s_r.dp_write <= 1'b0;
            s_r.dp_idx <= 8'h00;
            s_r.rdata <= RDATA_ZERO;
            s_r.ready <= 1'b1;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.ready;
    assign hresp = HRESP_OKAY;
    assign interrupt_request_out = s_r.irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_frame_sync_monitor_alarm_latch: assert property ( // [R02]
        frame_sync_monitor_alarm && !s_r.prev_frame_sync_monitor_alarm
        |=> s_r.status[EVT_FRAME_SYNC])
        else $error("frame-sync event not latched");

    a_lock_change: assert property ( // [R03]
        (aux_loop_lock != s_r.prev_lock) |=> s_r.status[EVT_AUX_LOCK])
        else $error("aux lock change not latched");

    a_noin_sticky: assert property ( // [R05]
        aux_no_valid_input |=> s_r.status[EVT_AUX_NO_INPUT])
        else $error("no-input bit cleared while condition holds");

    a_irq_gate: assert property ( // [R06]
        interrupt_request_out == |(s_r.status & s_r.enable))
        else $error("interrupt does not follow enabled events");

    a_w1c_clear: assert property ( // [R04]
        s_r.dp_valid && s_r.dp_write
        && s_r.dp_idx == IDX_EVENT_STATUS_THREE
        && hwdata[EVT_PHASE_MON] && !phase_monitor_alarm
        |=> !s_r.status[EVT_PHASE_MON])
        else $error("phase alarm bit not cleared by one");

    a_zero_keeps: assert property ( // [R22]
        s_r.dp_valid && s_r.dp_write && hwdata[7:0] == 8'h00
        |=> ($past(s_r.status) & ~s_r.status) == 8'h00)
        else $error("zero write cleared a latched bit");

    a_loop_frequency_readout_high: assert property ( // [R01]
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
        && haddr == {22'h0, IDX_LOOP_FREQUENCY_READOUT_HIGH, 2'b00}
        |=> hrdata[31:3] == 29'h0
            && hrdata[2:0] == $past(s_r.loop_frequency_readout_snap[18:16]))
        else $error("high frequency bits misplaced");

    a_view_table: assert property ( // [R16]
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
        && haddr == {22'h0, IDX_PRIORITY_TABLE_ONE, 2'b00}
        |=> hrdata[3:0] == $past(ref_sel) && hrdata[7:4] == $past(ref_top))
        else $error("priority table one read wrong");

    a_code_legal: assert property ( // [R13]
        ref_top != 4'h7 && ref_top <= REF_IC9
        && ref_sel != 4'h7 && ref_sel <= REF_IC9)
        else $error("unused reference code reported");

    a_rank_order: assert property ( // [R18]
        ref_top == REF_NONE |-> ref_second == REF_NONE
                                && ref_third == REF_NONE)
        else $error("ranking holds a hole");

    a_bus_okay: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready okay");

    a_operating_state_live: assert property ( // [R07]
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
        && haddr == {22'h0, IDX_OPERATING_STATE, 2'b00}
        |=> hrdata == {24'h0, $past(frame_sync_monitor_alarm),
                       $past(aux_loop_lock), $past(main_loop_soft_alarm),
                       $past(aux_loop_soft_alarm), 1'b0,
                       $past(main_loop_state)})
        else $error("operating state read wrong");

    a_lock_clear: assert property ( // [R03]
        s_r.dp_valid && s_r.dp_write
        && s_r.dp_idx == IDX_EVENT_STATUS_THREE
        && hwdata[EVT_AUX_LOCK] && aux_loop_lock == s_r.prev_lock
        |=> !s_r.status[EVT_AUX_LOCK])
        else $error("aux lock bit not cleared by one");

    // a write in the same cycle may mask the enable, so it is left out
    a_irq_raise: assert property ( // [R06]
        s_r.enable[EVT_AUX_NO_INPUT] && aux_no_valid_input
        && !(s_r.dp_valid && s_r.dp_write)
        |=> interrupt_request_out)
        else $error("enabled event raised no interrupt");

    a_rank_third: assert property ( // [R19]
        ref_second == REF_NONE |-> ref_third == REF_NONE)
        else $error("third rank set without a second");

    a_rdata_holds: assert property (
        !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved without a read");

endmodule : dsr_status_regs

`default_nettype wire

// file: verification/test_dsr_status_regs.sv
// test_dsr_status_regs: self-checking bench for the status register bank.
// assumes: zero-wait ahb-lite slave, live inputs synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
module test_dsr_status_regs
    import dsr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, seed, r;
    logic [1:0] htrans;
    logic [2:0] hsize, m_state;
    logic fs_alarm, aux_lock, ph_alarm, no_input, m_soft, a_soft, pv;
    logic [LOOP_FREQUENCY_READOUT_WIDTH-1:0] m_loop_frequency_readout, a_loop_frequency_readout, f;
    logic [7:0] v1, v2;
    logic [15:0] t;
    dsr_refs_t m_refs, a_refs;
    int error_cnt, comparisons;
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0] refs [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};

    assign hready = hreadyout;

    dsr_status_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .frame_sync_monitor_alarm(fs_alarm), .aux_loop_lock(aux_lock),
        .phase_monitor_alarm(ph_alarm), .aux_no_valid_input(no_input),
        .main_loop_soft_alarm(m_soft), .aux_loop_soft_alarm(a_soft),
        .main_loop_state(m_state), .main_loop_frequency(m_loop_frequency_readout),
        .aux_loop_frequency(a_loop_frequency_readout), .main_refs(m_refs), .aux_refs(a_refs),
        .interrupt_request_out(irq));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // half the nibbles are legal codes, the rest raw, of which codes 0 and 7 are unusable
    function automatic logic [3:0] pick(logic [3:0] x);
        return x[3] ? refs[x[2:0]] : x;
    endfunction : pick

    function automatic logic ok(logic [3:0] c, logic [7:0] a, logic [7:0] b);
        if (c >= 4'h1 && c <= 4'h6) return a[c - 4'h1];
        if (c == REF_IC8) return a[VAL1_IC8_BIT];
        if (c == REF_IC9) return b[VAL2_IC9_BIT];
        return 1'b0;
    endfunction : ok

    // returns {table one, table two}; unusable entries drop out, rest close up
    function automatic logic [15:0] tables(dsr_refs_t x, logic [7:0] a,
                                          logic [7:0] b);
        logic [3:0] q[$];
        logic [3:0] s;
        if (ok(x.top, a, b)) q.push_back(x.top);
        if (ok(x.second, a, b)) q.push_back(x.second);
        if (ok(x.third, a, b)) q.push_back(x.third);
        while (q.size() < 3) q.push_back(REF_NONE);
        s = ok(x.selected, a, b) ? x.selected : REF_NONE;
        return {q[0], s, q[2], q[1]};
    endfunction : tables

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // one single transfer; request held until hready is sampled high
    task automatic xfer(logic w, logic [7:0] idx, logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1);
        rd = hrdata;
        // zero wait states: one address and one data phase
        chk("bus wait", n, 32'd2);
        chk("bus response", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : xfer

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        xfer(1'b1, idx, {24'h0, d});
    endtask : wr

    task automatic rdchk(string nm, logic [7:0] idx, logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk

    task automatic drive(int b, logic v);
        case (b)
            EVT_FRAME_SYNC: fs_alarm <= v;
            EVT_AUX_LOCK: aux_lock <= v;
            EVT_PHASE_MON: ph_alarm <= v;
            default: no_input <= v;
        endcase
    endtask : drive

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        {hsel, hwrite, fs_alarm, aux_lock, ph_alarm, no_input} = 6'h0;
        {m_soft, a_soft, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        m_state = MAIN_FREE_RUN;
        m_loop_frequency_readout = '0;
        a_loop_frequency_readout = '0;
        m_refs = '0;
        a_refs = '0;
        seed = 32'd20;
        error_cnt = 0;
        comparisons = 0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        // reset values, ignored writes and the unmapped hole
        rdchk("status", IDX_EVENT_STATUS_THREE, 32'h50);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(IDX_EVENT_STATUS_THREE, 8'h00);
        rdchk("status", IDX_EVENT_STATUS_THREE, 32'h50);
        wr(IDX_OPERATING_STATE, 8'hff);
        rdchk("operating_state", IDX_OPERATING_STATE, 32'h01);
        wr(IDX_EVENT_STATUS_THREE, 8'hf0);
        rdchk("status", IDX_EVENT_STATUS_THREE, 32'h0);
        wr(8'h20, 8'hff);
        rdchk("unmapped", 8'h20, 32'h0);
        $display("reset and access test done");
        // each event: raise, clear, drop, clear
        for (int b = 4; b < 8; b++) begin
            drive(b, 1'b1);
            tick(2);
            rdchk("event", IDX_EVENT_STATUS_THREE, 32'h1 << b);
            wr(IDX_EVENT_STATUS_THREE, 8'h1 << b);
            rdchk("clear", IDX_EVENT_STATUS_THREE, b == 4 ? 32'h10 : 32'h0);
            drive(b, 1'b0);
            tick(2);
            rdchk("drop", IDX_EVENT_STATUS_THREE,
                  b == 6 ? 32'h40 : (b == 4 ? 32'h10 : 32'h0));
            wr(IDX_EVENT_STATUS_THREE, 8'h1 << b);
            rdchk("cleared", IDX_EVENT_STATUS_THREE, 32'h0);
        end
        $display("event latch test done");
        // interrupt raised, masked, unmasked and cleared per bit
        for (int b = 4; b < 8; b++) begin
            wr(IDX_EVENT_ENABLE_THREE, 8'h1 << b);
            drive(b, 1'b1);
            tick(3);
            chk("irq set", {31'h0, irq}, 32'h1);
            wr(IDX_EVENT_ENABLE_THREE, 8'h0);
            tick(2);
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr(IDX_EVENT_ENABLE_THREE, 8'h1 << b);
            tick(2);
            chk("irq unmasked", {31'h0, irq}, 32'h1);
            drive(b, 1'b0);
            wr(IDX_EVENT_STATUS_THREE, 8'hf0);
            tick(2);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        wr(IDX_EVENT_ENABLE_THREE, 8'h0);
        $display("interrupt test done");
        // live operating state
        repeat (24) begin
            r = xs();
            {fs_alarm, aux_lock, m_soft, a_soft} <= r[3:0];
            m_state <= codes[r[15:8] % 6];
            tick(1);
            rdchk("operating_state", IDX_OPERATING_STATE,
                  {24'h0, r[3:0], 1'b0, codes[r[15:8] % 6]});
        end
        $display("operating state test done");
        // ranking and selection; early passes keep reset validation
        for (int i = 0; i < 32; i++) begin
            r = xs();
            m_refs <= {pick(r[3:0]), pick(r[7:4]), pick(r[11:8]),
                       pick(r[15:12])};
            a_refs <= {pick(r[19:16]), pick(r[23:20]), pick(r[27:24]),
                       pick(r[31:28])};
            v1 = i < 4 ? RST_VALIDATION_ONE : (i == 8 ? 8'h00 : r[7:0]);
            v2 = i < 4 ? RST_VALIDATION_TWO : (i == 8 ? 8'h00 : r[8 +: 8]);
            pv = r[i % 32];
            if (i >= 4) wr(IDX_VALIDATION_CONTROL_ONE, v1);
            if (i >= 4) wr(IDX_VALIDATION_CONTROL_TWO, v2);
            wr(IDX_MODE_CONTROL_ELEVEN, {7'h0, pv});
            wr(IDX_MODE_CONTROL_THREE, {7'h0, r[5]});
            rdchk("revertive_enable", IDX_MODE_CONTROL_THREE, {31'h0, r[5]});
            t = tables(pv ? a_refs : m_refs, v1, v2);
            rdchk("table one", IDX_PRIORITY_TABLE_ONE, {24'h0, t[15:8]});
            rdchk("table two", IDX_PRIORITY_TABLE_TWO, {24'h0, t[7:0]});
        end
        $display("priority table test done");
        // frequency snapshot survives a change between the three reads
        for (int p = 0; p < 2; p++) begin
            wr(IDX_MODE_CONTROL_ELEVEN, p[7:0]);
            r = xs();
            m_loop_frequency_readout <= r[18:0];
            a_loop_frequency_readout <= r[31:13];
            tick(1);
            f = p ? a_loop_frequency_readout : m_loop_frequency_readout;
            rdchk("loop_frequency_readout low", IDX_LOOP_FREQUENCY_READOUT_LOW, {24'h0, f[7:0]});
            m_loop_frequency_readout <= ~m_loop_frequency_readout;
            a_loop_frequency_readout <= ~a_loop_frequency_readout;
            rdchk("loop_frequency_readout mid", IDX_LOOP_FREQUENCY_READOUT_MID, {24'h0, f[15:8]});
            rdchk("loop_frequency_readout high", IDX_LOOP_FREQUENCY_READOUT_HIGH, {29'h0, f[18:16]});
        end
        $display("frequency test done");
        end_of_test();
    end
endmodule : test_dsr_status_regs
`default_nettype wire
